// file: rtl/mcdd_arbiter.sv
// Channel arbiter: priority levels, fairness slots and round robin
`timescale 1ns/100ps
`include "mcdd_cfg.svh"
module mcdd_arbiter
  import mcdd_pkg::*;
#(
  parameter int NCH = `MCDD_NCH
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [NCH-1:0] req_i,
  input wire logic [3*NCH-1:0] prio_i,
  input wire logic [NCH-1:0] rr_dis_i,
  input wire logic fair_en_i,
  input wire logic take_i,
  output logic gnt_vld_o,
  output mcdd_ch_t gnt_ch_o
);
  logic [7:0] lvl_req;
  mcdd_prio_t lvl, slot_lvl;
  logic [6:0] slot_q;
  mcdd_ch_t last_q [8];

  always_comb begin
    int j;
    j = 0;
    lvl_req = '0;
    for (int i = 0; i < NCH; i++) begin
      if (req_i[i]) begin
        lvl_req[prio_i[3*i +: 3]] = 1'b1;
      end
    end
    lvl = 3'h7;
    for (int l = 7; l >= 0; l--) begin
      if (lvl_req[l]) begin
        lvl = 3'(l);
      end
    end
    // Slot owner is the trailing-zero count plus two; slots 0 and 64 are left to strict order
    slot_lvl = 3'h0;
    for (int b = 5; b >= 0; b--) begin
      if (slot_q[b]) begin
        slot_lvl = 3'(b + 2);
      end
    end
    if (fair_en_i && lvl_req[1:0] == 2'b00 && lvl_req[slot_lvl]) begin
      lvl = slot_lvl;
    end
    gnt_ch_o = '0;
    for (int k = NCH; k >= 1; k--) begin
      j = (int'(last_q[lvl]) + k) % NCH;
      if (req_i[j] && prio_i[3*j +: 3] == lvl) begin
        gnt_ch_o = mcdd_ch_t'(j);
      end
    end
    for (int i = NCH - 1; i >= 0; i--) begin
      if (req_i[i] && rr_dis_i[i] && prio_i[3*i +: 3] == lvl) begin
        gnt_ch_o = mcdd_ch_t'(i);
      end
    end
    gnt_vld_o = |req_i;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      slot_q <= 7'h0;
      for (int l = 0; l < 8; l++) begin
        last_q[l] <= '0;
      end
    end else if (take_i) begin
      last_q[lvl] <= gnt_ch_o;
      if (fair_en_i && lvl >= 3'h2) begin
        slot_q <= slot_q + 7'h1;
      end
    end
  end
endmodule

// file: rtl/mcdd_cfg.svh
// Constants for the multichannel descriptor DMA: offsets, fields, resets and counts
`ifndef MCDD_CFG_SVH
`define MCDD_CFG_SVH
`define MCDD_NCH 24
`define MCDD_DESC_END 7'h7f
`define MCDD_STARVE_CYC 16
`define MCDD_A_GCTRL 12'h000
`define MCDD_A_GSTAT 12'h004
`define MCDD_A_TRIG 12'h008
`define MCDD_A_CANCEL 12'h00c
`define MCDD_A_PAUSE 12'h010
`define MCDD_A_CHCFG_HI 5'h02
`define MCDD_TDWIN_BIT 11
`define MCDD_DESC_BASE_HI 20'h40008
`define MCDD_CF_PRIO 2:0
`define MCDD_CF_RRDIS 3
`define MCDD_CF_HWEN 4
`define MCDD_CF_DESC 11:5
`define MCDD_CF_CHAIN 16:12
`define MCDD_CF_MASK 32'h0001ffff
`define MCDD_CF_RST 32'h0001f000
`define MCDD_TW_LEN 15:0
`define MCDD_TW_BURST 22:16
`define MCDD_TW_NEXT 29:23
`define MCDD_TW_IRQ0 30
`define MCDD_TW_IRQ1 31
`define MCDD_TW_INF 0
`define MCDD_STEP 32'h00000004
`define MCDD_RESP_OK 2'b00
`define MCDD_RESP_ERR 2'b10
`endif

// file: rtl/mcdd_pkg.sv
// Types shared by the descriptor DMA modules
package mcdd_pkg;
  typedef logic [4:0] mcdd_ch_t;
  typedef logic [2:0] mcdd_prio_t;
  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_FETCH = 5'h02,
    S_RD = 5'h04,
    S_WR = 5'h08,
    S_DONE = 5'h10
  } mcdd_st_e;
endpackage

// file: rtl/mcdd_td_mem.sv
// Two-port descriptor store with registered read data
`timescale 1ns/100ps
module mcdd_desc_mem #(
  parameter int AW = 9
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic a_we_i,
  input wire logic [AW-1:0] a_addr_i,
  input wire logic [31:0] a_wdata_i,
  output logic [31:0] a_rdata_o,
  input wire logic b_we_i,
  input wire logic [AW-1:0] b_addr_i,
  input wire logic [31:0] b_wdata_i,
  output logic [31:0] b_rdata_o
);
  logic [31:0] mem [2**AW];

  // Engine write lands last so a chained update beats a same-word bus write
  always_ff @(posedge clk_i) begin
    if (a_we_i) begin
      mem[a_addr_i] <= a_wdata_i;
    end
    if (b_we_i) begin
      mem[b_addr_i] <= b_wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      a_rdata_o <= 32'h0;
      b_rdata_o <= 32'h0;
    end else begin
      a_rdata_o <= mem[a_addr_i];
      b_rdata_o <= mem[b_addr_i];
    end
  end
endmodule

// file: rtl/mcdd_top.sv
// Multichannel descriptor DMA: register slave, channel state and transfer engine
//
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "mcdd_cfg.svh"
module mcdd_top
  import mcdd_pkg::*;
#(
  parameter int NCH = `MCDD_NCH,
  parameter int STARVE = `MCDD_STARVE_CYC
) (
  input wire logic SYS_CLK_I,
  input wire logic RESET_N_I,
  input wire logic [11:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [11:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire logic [NCH-1:0] TRIG_I,
  input wire logic CPU_REQ_I,
  output logic M_REQ_O,
  output logic M_WE_O,
  output logic [31:0] M_ADDR_O,
  output logic [31:0] M_WDATA_O,
  input wire logic M_DONE_I,
  input wire logic [31:0] M_RDATA_I,
  output logic [NCH-1:0] TERM0_O,
  output logic [NCH-1:0] TERM1_O
);
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RESET_N_I);

  // ==========================================================
  // Declarations
  logic awv_q, wv_q, bv_q, rph_q, rv_q, wr_go, wr_ok, rd_ok;
  logic [11:0] aw_q, ra_q;
  logic [31:0] wd_q, ws_m, rd_q, rmux, a_rdata, b_rdata;
  logic [3:0] ws_q;
  logic [1:0] bresp_q, rresp_q;
  logic fair_q;
  logic [NCH-1:0] pause_q, cxl_q, trig_wr, cxl_wr, start, req, rrdis_v, done_q;
  logic [NCH-1:0] act_q, ld_q, inf_q, trg_s1_q, trg_s2_q, trg_s3_q;
  logic [3*NCH-1:0] prio_v;
  logic [31:0] cfg_q [NCH];
  logic [6:0] desc_q [NCH];
  logic [31:0] src_q [NCH], dst_q [NCH], tw_q [NCH];
  logic [16:0] rem_q [NCH];
  mcdd_st_e st_q;
  mcdd_ch_t ch_q, gnt_ch;
  logic gnt_vld, in_win, last_beat, burst_end, beat_done, m_want;
  logic [2:0] fcnt_q;
  logic [6:0] bcnt_q;
  logic [31:0] buf_q, maddr_q, cur_src, cur_dst, cur_tw;
  logic [7:0] wait_q;

  function automatic logic [6:0] blen(input logic [31:0] tw);
    return (tw[`MCDD_TW_BURST] == 7'h0) ? 7'h1 : tw[`MCDD_TW_BURST];
  endfunction

  function automatic logic cfg_hit(input logic [11:0] a);
    return a[11:7] == `MCDD_A_CHCFG_HI && a[6:2] < 5'(NCH);
  endfunction

  function automatic logic map_hit(input logic [11:0] a);
    return a == `MCDD_A_GCTRL || a == `MCDD_A_GSTAT || a == `MCDD_A_TRIG
      || a == `MCDD_A_CANCEL || a == `MCDD_A_PAUSE || cfg_hit(a) || a[`MCDD_TDWIN_BIT];
  endfunction

  // ==========================================================
  // Register bus write side
  assign S_AXI_AWREADY_O = !awv_q;
  assign S_AXI_WREADY_O = !wv_q;
  assign S_AXI_BVALID_O = bv_q;
  assign S_AXI_BRESP_O = bresp_q;
  assign wr_go = awv_q && wv_q && !bv_q;
  assign wr_ok = map_hit(aw_q);
  assign ws_m = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}}, {8{ws_q[0]}}};
  assign trig_wr = (wr_go && aw_q == `MCDD_A_TRIG) ? (wd_q[NCH-1:0] & ws_m[NCH-1:0]) : '0;
  assign cxl_wr = (wr_go && aw_q == `MCDD_A_CANCEL) ? (wd_q[NCH-1:0] & ws_m[NCH-1:0]) : '0;

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      awv_q <= 1'b0;
      wv_q <= 1'b0;
      bv_q <= 1'b0;
      aw_q <= 12'h0;
      wd_q <= 32'h0;
      ws_q <= 4'h0;
      bresp_q <= `MCDD_RESP_OK;
    end else begin
      if (S_AXI_AWVALID_I && !awv_q) begin
        awv_q <= 1'b1;
        aw_q <= S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I && !wv_q) begin
        wv_q <= 1'b1;
        wd_q <= S_AXI_WDATA_I;
        ws_q <= S_AXI_WSTRB_I;
      end
      if (wr_go) begin
        awv_q <= 1'b0;
        wv_q <= 1'b0;
        bv_q <= 1'b1;
        bresp_q <= wr_ok ? `MCDD_RESP_OK : `MCDD_RESP_ERR;
      end else if (bv_q && S_AXI_BREADY_I) begin
        bv_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      fair_q <= 1'b0;
      pause_q <= '0;
      for (int i = 0; i < NCH; i++) begin
        cfg_q[i] <= `MCDD_CF_RST;
      end
    end else if (wr_go) begin
      if (aw_q == `MCDD_A_GCTRL) begin
        fair_q <= ws_q[0] ? wd_q[0] : fair_q;
      end
      if (aw_q == `MCDD_A_PAUSE) begin
        pause_q <= (pause_q & ~ws_m[NCH-1:0]) | (wd_q[NCH-1:0] & ws_m[NCH-1:0]);
      end
      if (cfg_hit(aw_q)) begin
        cfg_q[aw_q[6:2]] <= ((cfg_q[aw_q[6:2]] & ~ws_m) | (wd_q & ws_m)) & `MCDD_CF_MASK;
      end
    end
  end

  // ==========================================================
  // Register bus read side
  assign S_AXI_ARREADY_O = !rph_q && !rv_q && !wr_go;
  assign S_AXI_RVALID_O = rv_q;
  assign S_AXI_RDATA_O = rd_q;
  assign S_AXI_RRESP_O = rresp_q;
  assign rd_ok = map_hit(ra_q);

  always_comb begin
    rmux = 32'h0;
    if (ra_q[`MCDD_TDWIN_BIT]) begin
      rmux = a_rdata;
    end else if (cfg_hit(ra_q)) begin
      rmux = cfg_q[ra_q[6:2]];
    end else if (ra_q == `MCDD_A_GCTRL) begin
      rmux = {31'h0, fair_q};
    end else if (ra_q == `MCDD_A_GSTAT) begin
      rmux = 32'(act_q);
    end else if (ra_q == `MCDD_A_PAUSE) begin
      rmux = 32'(pause_q);
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rph_q <= 1'b0;
      rv_q <= 1'b0;
      ra_q <= 12'h0;
      rd_q <= 32'h0;
      rresp_q <= `MCDD_RESP_OK;
    end else begin
      if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
        rph_q <= 1'b1;
        ra_q <= S_AXI_ARADDR_I;
      end
      if (rph_q) begin
        rph_q <= 1'b0;
        rv_q <= 1'b1;
        rd_q <= rmux;
        rresp_q <= rd_ok ? `MCDD_RESP_OK : `MCDD_RESP_ERR;
      end else if (rv_q && S_AXI_RREADY_I) begin
        rv_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Descriptor store
  // bus port writes any time; partial strobes are ignored here
  // engine writes aimed at the window
  mcdd_desc_mem #(.AW(9)) u_mcdd_desc_mem (
    .clk_i(SYS_CLK_I),
    .rst_n_i(RESET_N_I),
    .a_we_i(wr_go && aw_q[`MCDD_TDWIN_BIT] && ws_q == 4'hf),
    .a_addr_i(wr_go ? aw_q[10:2] : S_AXI_ARADDR_I[10:2]),
    .a_wdata_i(wd_q),
    .a_rdata_o(a_rdata),
    .b_we_i(st_q == S_WR && in_win),
    .b_addr_i(st_q == S_WR ? cur_dst[10:2] : {desc_q[ch_q], fcnt_q[1:0]}),
    .b_wdata_i(buf_q),
    .b_rdata_o(b_rdata)
  );

  // ==========================================================
  // Channel triggers and arbitration
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      trg_s1_q <= '0;
      trg_s2_q <= '0;
      trg_s3_q <= '0;
    end else begin
      trg_s1_q <= TRIG_I;
      trg_s2_q <= trg_s1_q;
      trg_s3_q <= trg_s2_q;
    end
  end

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    logic [4:0] csrc;
    assign csrc = cfg_q[g][`MCDD_CF_CHAIN];
    // routed edge, CPU write or chain done
    assign start[g] = (trg_s2_q[g] & ~trg_s3_q[g] & cfg_q[g][`MCDD_CF_HWEN]) | trig_wr[g]
      | (csrc < 5'(NCH) && done_q[csrc]);
    assign req[g] = act_q[g] & ~pause_q[g] & ~cxl_q[g];
    assign prio_v[3*g +: 3] = cfg_q[g][`MCDD_CF_PRIO];
    assign rrdis_v[g] = cfg_q[g][`MCDD_CF_RRDIS];
  end

  mcdd_arbiter #(.NCH(NCH)) u_mcdd_arbiter (
    .clk_i(SYS_CLK_I),
    .rst_n_i(RESET_N_I),
    .req_i(req),
    .prio_i(prio_v),
    .rr_dis_i(rrdis_v),
    .fair_en_i(fair_q),
    .take_i(st_q == S_IDLE && gnt_vld),
    .gnt_vld_o(gnt_vld),
    .gnt_ch_o(gnt_ch)
  );

  pause_gate_a: assert property (st_q == S_IDLE && gnt_vld |->
    !pause_q[gnt_ch] && !cxl_q[gnt_ch]) else $error("paused or cancelled channel granted");

  // ==========================================================
  // Channel activity
  // per-channel state for all channels
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      act_q <= '0;
      ld_q <= '0;
      cxl_q <= '0;
      for (int i = 0; i < NCH; i++) begin
        desc_q[i] <= 7'h0;
      end
    end else begin
      // cancel sticks until applied; a new request wins over the clear
      cxl_q <= (cxl_q & act_q) | cxl_wr;
      for (int i = 0; i < NCH; i++) begin
        if (start[i] && !act_q[i] && cfg_q[i][`MCDD_CF_DESC] != `MCDD_DESC_END) begin
          act_q[i] <= 1'b1;
          ld_q[i] <= 1'b1;
          desc_q[i] <= cfg_q[i][`MCDD_CF_DESC];
        end else if (cxl_q[i] && !(st_q != S_IDLE && ch_q == 5'(i))) begin
          act_q[i] <= 1'b0;
        end
      end
      if (st_q == S_FETCH && fcnt_q == 3'h4) begin
        ld_q[ch_q] <= 1'b0;
      end
      if (st_q == S_DONE) begin
        if (cur_tw[`MCDD_TW_NEXT] != `MCDD_DESC_END && !cxl_q[ch_q]) begin
          desc_q[ch_q] <= cur_tw[`MCDD_TW_NEXT];
          ld_q[ch_q] <= 1'b1;
        end else begin
          act_q[ch_q] <= 1'b0;
        end
      end
    end
  end

  self_loop_a: assert property (st_q == S_DONE && !cxl_q[ch_q]
    && cur_tw[`MCDD_TW_NEXT] == desc_q[ch_q] |=> act_q[$past(ch_q)] && ld_q[$past(ch_q)])
    else $error("self-linked descriptor did not rearm");

  // ==========================================================
  // Transfer engine
  assign cur_src = src_q[ch_q];
  assign cur_dst = dst_q[ch_q];
  assign cur_tw = tw_q[ch_q];
  assign in_win = cur_dst[31:12] == `MCDD_DESC_BASE_HI;
  assign last_beat = !inf_q[ch_q] && rem_q[ch_q] <= 17'h4;
  assign burst_end = bcnt_q <= 7'h4;
  assign m_want = st_q == S_RD || (st_q == S_WR && !in_win);
  assign beat_done = st_q == S_WR && (in_win || (M_REQ_O && M_DONE_I));

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      st_q <= S_IDLE;
      ch_q <= '0;
      fcnt_q <= 3'h0;
      bcnt_q <= 7'h0;
      buf_q <= 32'h0;
      maddr_q <= 32'h0;
      inf_q <= '0;
      for (int i = 0; i < NCH; i++) begin
        src_q[i] <= 32'h0;
        dst_q[i] <= 32'h0;
        tw_q[i] <= 32'h0;
        rem_q[i] <= 17'h0;
      end
    end else begin
      case (st_q)
        S_IDLE: begin
          if (gnt_vld) begin
            ch_q <= gnt_ch;
            fcnt_q <= 3'h0;
            maddr_q <= src_q[gnt_ch];
            bcnt_q <= blen(tw_q[gnt_ch]);
            st_q <= ld_q[gnt_ch] ? S_FETCH : S_RD;
          end
        end
        S_FETCH: begin
          fcnt_q <= fcnt_q + 3'h1;
          case (fcnt_q)
            3'h1: src_q[ch_q] <= b_rdata;
            3'h2: dst_q[ch_q] <= b_rdata;
            3'h3: tw_q[ch_q] <= b_rdata;
            3'h4: begin
              inf_q[ch_q] <= b_rdata[`MCDD_TW_INF];
              rem_q[ch_q] <= {1'b0, cur_tw[`MCDD_TW_LEN]} + 17'h1;
              bcnt_q <= blen(cur_tw);
              maddr_q <= cur_src;
              st_q <= S_RD;
            end
            default: begin
            end
          endcase
        end
        S_RD: begin
          if (M_REQ_O && M_DONE_I) begin
            buf_q <= M_RDATA_I;
            maddr_q <= cur_dst;
            st_q <= S_WR;
          end
        end
        S_WR: begin
          if (beat_done) begin
            src_q[ch_q] <= cur_src + `MCDD_STEP;
            dst_q[ch_q] <= cur_dst + `MCDD_STEP;
            rem_q[ch_q] <= inf_q[ch_q] ? rem_q[ch_q] : rem_q[ch_q] - 17'h4;
            bcnt_q <= burst_end ? 7'h0 : bcnt_q - 7'h4;
            maddr_q <= cur_src + `MCDD_STEP;
            if (last_beat) begin
              st_q <= S_DONE;
            end else if (burst_end || pause_q[ch_q] || cxl_q[ch_q]) begin
              st_q <= S_IDLE;
            end else begin
              st_q <= S_RD;
            end
          end
        end
        S_DONE: st_q <= S_IDLE;
        default: st_q <= S_IDLE;
      endcase
    end
  end

  sequence fetch_s;
    (st_q == S_FETCH) [*5] ##1 (st_q == S_RD);
  endsequence
  fetch_order_a: assert property ($rose(st_q == S_FETCH) |-> fetch_s)
    else $error("descriptor fetch not five cycles");
  len_end_a: assert property (beat_done && last_beat |=> st_q == S_DONE)
    else $error("count exhausted without completion");
  burst_hold_a: assert property (st_q != S_IDLE && $past(st_q) != S_IDLE |->
    $stable(ch_q)) else $error("channel switched inside a burst");

  // ==========================================================
  // System bus master, yielding to the CPU
  // hold off while CPU contends, until STARVE wait cycles have passed
  assign M_REQ_O = m_want && (!CPU_REQ_I || wait_q >= 8'(STARVE));
  assign M_WE_O = st_q == S_WR;
  assign M_ADDR_O = maddr_q;
  assign M_WDATA_O = buf_q;

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      wait_q <= 8'h0;
    end else if (M_REQ_O && M_DONE_I) begin
      wait_q <= 8'h0;
    end else if (m_want && CPU_REQ_I && wait_q < 8'(STARVE)) begin
      wait_q <= wait_q + 8'h1;
    end
  end

  cpu_first_a: assert property (CPU_REQ_I && wait_q < 8'(STARVE) |-> !M_REQ_O)
    else $error("engine requested over the CPU");
  starve_bound_a: assert property (m_want && !M_REQ_O |->
    ##[1:STARVE] (M_REQ_O || !m_want)) else $error("engine starved by CPU");

  // ==========================================================
  // Completion outputs
  // two completion pulses
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      TERM0_O <= '0;
      TERM1_O <= '0;
      done_q <= '0;
    end else begin
      TERM0_O <= '0;
      TERM1_O <= '0;
      done_q <= '0;
      if (st_q == S_DONE) begin
        TERM0_O[ch_q] <= cur_tw[`MCDD_TW_IRQ0];
        TERM1_O[ch_q] <= cur_tw[`MCDD_TW_IRQ1];
        done_q[ch_q] <= cur_tw[`MCDD_TW_NEXT] == `MCDD_DESC_END || cxl_q[ch_q];
      end
    end
  end

  term_cause_a: assert property (|TERM0_O || |TERM1_O |-> $past(st_q) == S_DONE)
    else $error("completion pulse without a finished descriptor");
endmodule

// file: tb/mcdd_mem_model.sv
// Memory partner on the engine's master port, prompt or slow
`timescale 1ns/100ps
module mcdd_mem_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic slow_i,
  output logic done_o,
  output logic [31:0] rdata_o
);
  logic [31:0] mem [0:63];
  logic [31:0] last_q;
  logic [1:0] cnt_q;
  // Slow mode holds each beat for three wait cycles
  assign done_o = req_i && (slow_i ? cnt_q == 2'h3 : 1'b1);
  // Outside an accepted read beat the bus shows junk, never stale data
  assign rdata_o = (done_o && !we_i) ? mem[addr_i[7:2]] : ~last_q;
  initial begin
    for (int i = 0; i < 64; i++) begin
      mem[i] = 32'h5a000000 + 32'(i);
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 2'h0;
      last_q <= 32'h0;
    end else begin
      cnt_q <= (req_i && !done_o) ? cnt_q + 2'h1 : 2'h0;
      if (done_o && !we_i) begin
        last_q <= rdata_o;
      end
    end
  end
  always @(posedge clk_i) begin
    if (done_o && we_i) begin
      mem[addr_i[7:2]] <= wdata_i;
    end
  end
endmodule

// file: tb/tb_multichannel_descriptor_dma.sv
// Self-checking bench for the descriptor DMA engine
`timescale 1ns/100ps
module tb_multichannel_descriptor_dma;
  typedef struct {logic we; logic [11:0] a; logic [31:0] d; logic [1:0] r;} mcdd_row_s;
  logic clk, rst_n, awv, wv, bry, arv, rry, cpu, slow;
  logic awr, wr, bv, arr, rv, mreq, mwe, mdone, ra, rw, rb;
  logic [11:0] awa, ara;
  logic [1:0] br, rr, e;
  logic [23:0] trig, t0, t1;
  logic [31:0] wd, rd, maddr, mwd, mrd, v;
  int bad_count = 0;
  int checked = 0;
  int n;
  mcdd_row_s rows [15] = '{
    '{1'b0, 12'h000, 32'h0, 2'b00}, // fairness off
    '{1'b1, 12'h000, 32'h1, 2'b00},
    '{1'b0, 12'h000, 32'h1, 2'b00},
    '{1'b1, 12'h000, 32'h0, 2'b00},
    '{1'b0, 12'h100, 32'h0001f000, 2'b00}, // config default
    '{1'b1, 12'h104, 32'hffffffff, 2'b00},
    '{1'b0, 12'h104, 32'h0001ffff, 2'b00}, // opt-out bit kept
    '{1'b1, 12'h010, 32'hffffffff, 2'b00},
    '{1'b0, 12'h010, 32'h00ffffff, 2'b00}, // one stall bit per channel
    '{1'b1, 12'h010, 32'h0, 2'b00},
    '{1'b0, 12'h008, 32'h0, 2'b00}, // start register reads zero
    '{1'b0, 12'h160, 32'h0, 2'b10}, // no channel past the last
    '{1'b1, 12'h160, 32'h1, 2'b10},
    '{1'b0, 12'h014, 32'h0, 2'b10},
    '{1'b0, 12'h004, 32'h0, 2'b00}};
  mcdd_top #(.NCH(24), .STARVE(2)) u_mcdd_top (
    .SYS_CLK_I(clk), .RESET_N_I(rst_n), .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv),
    .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wv),
    .S_AXI_WREADY_O(wr), .S_AXI_BRESP_O(br), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bry),
    .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
    .S_AXI_RDATA_O(rd), .S_AXI_RRESP_O(rr), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rry),
    .TRIG_I(trig), .CPU_REQ_I(cpu), .M_REQ_O(mreq), .M_WE_O(mwe), .M_ADDR_O(maddr),
    .M_WDATA_O(mwd), .M_DONE_I(mdone), .M_RDATA_I(mrd), .TERM0_O(t0), .TERM1_O(t1));
  mcdd_mem_model u_mcdd_mem_model (.clk_i(clk), .rst_n_i(rst_n), .req_i(mreq), .we_i(mwe),
    .addr_i(maddr), .wdata_i(mwd), .slow_i(slow), .done_o(mdone), .rdata_o(mrd));
  // ==========
  // Checking and closing
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic hang();
    bad_count++;
    test_done();
  endtask
  function automatic logic [31:0] pat(input int i);
    return 32'h5a000000 + 32'(i);
  endfunction
  function automatic logic [31:0] mm(input int i);
    return u_mcdd_mem_model.mem[i];
  endfunction
  // ==========
  // Register bus master, entered just after a rising edge
  task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    repeat (60) begin
      @(negedge clk);
      ra = awv & awr;
      rw = wv & wr;
      rb = bv;
      if (rb) chk({30'h0, br}, {30'h0, er});
      @(posedge clk);
      if (ra) awv <= 1'b0;
      if (rw) wv <= 1'b0;
      if (rb) return;
    end
    hang();
  endtask
  // Read into v and e; ready stays high so back-to-back calls never toggle it
  task automatic axr(input logic [11:0] a);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    repeat (60) begin
      @(negedge clk);
      ra = arv & arr;
      rb = rv;
      v = rd;
      e = rr;
      @(posedge clk);
      if (ra) arv <= 1'b0;
      if (rb) return;
    end
    hang();
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] x, input logic [1:0] er);
    axr(a);
    chk(v, x);
    chk({30'h0, e}, {30'h0, er});
  endtask
  // Descriptor with four-byte bursts; irq is {second, first}
  task automatic dsc(input int k, input logic [31:0] s, input logic [31:0] d,
                    input logic [6:0] nx, input logic [15:0] lm1, input logic [1:0] irq);
    logic [11:0] b;
    b = 12'h800 + 12'(16 * k);
    axw(b, s, 2'b00);
    axw(b + 12'h4, d, 2'b00);
    axw(b + 12'h8, {irq, nx, 7'h04, lm1}, 2'b00);
    axw(b + 12'hc, 32'h0, 2'b00);
  endtask
  task automatic chc(input int c, input logic [2:0] p, input logic [6:0] k, input logic hw);
    axw(12'h100 + 12'(4 * c), {15'h0, 5'h1f, k, hw, 1'b0, p}, 2'b00);
  endtask
  // Wait for the first completion pulse on any channel and compare the set
  task automatic fst(input logic [23:0] x);
    int k;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (t0 == 24'h0 && k < 400);
    chk({8'h0, t0}, {8'h0, x});
    if (t0 == 24'h0) hang();
  endtask
  task automatic wt(input int c, input logic s);
    repeat (400) begin
      @(negedge clk);
      if ((s ? t1[c] : t0[c]) === 1'b1) begin
        @(posedge clk);
        return;
      end
    end
    hang();
  endtask
  // ==========
  // Stimulus
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    {rst_n, awv, wv, bry, arv, rry, cpu, slow} = 8'h0;
    {awa, ara, wd, trig} = 80'h0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (rows[i]) begin
      if (rows[i].we) axw(rows[i].a, rows[i].d, rows[i].r);
      else rdc(rows[i].a, rows[i].d, rows[i].r);
    end
    dsc(0, 32'h10, 32'h80, 7'h01, 16'h7, 2'b01);
    dsc(1, 32'h18, 32'h88, 7'h7f, 16'h3, 2'b10);
    chc(0, 3'h2, 7'h0, 1'b0);
    cpu <= 1'b1;
    slow <= 1'b1;
    axw(12'h008, 32'h1, 2'b00);
    wt(0, 1'b0); // engine still finishes under a busy CPU
    wt(0, 1'b1);
    cpu <= 1'b0;
    slow <= 1'b0;
    chk(mm(32), pat(4));
    chk(mm(33), pat(5));
    chk(mm(34), pat(6));
    dsc(3, 32'h30, 32'h90, 7'h03, 16'h3, 2'b01);
    chc(1, 3'h3, 7'h3, 1'b0);
    axw(12'h008, 32'h2, 2'b00);
    wt(1, 1'b0);
    wt(1, 1'b0); // repeats with no new start
    axw(12'h00c, 32'h2, 2'b00);
    n = 0;
    do begin
      axr(12'h004);
      n++;
    end while (v[1] && n < 20);
    chk(v, 32'h0);
    chk({30'h0, e}, 32'h0);
    chk(mm(36), pat(12));
    dsc(4, 32'h20, 32'h40008050, 7'h05, 16'h3, 2'b00);
    dsc(5, 32'h0, 32'hc0, 7'h7f, 16'h3, 2'b01);
    chc(2, 3'h0, 7'h4, 1'b0);
    axw(12'h008, 32'h4, 2'b00);
    wt(2, 1'b0);
    rdc(12'h850, pat(8), 2'b00);
    chk(mm(48), pat(2));
    dsc(6, 32'h40, 32'ha0, 7'h7f, 16'h3, 2'b01);
    dsc(7, 32'h44, 32'ha4, 7'h7f, 16'h3, 2'b01);
    chc(3, 3'h5, 7'h6, 1'b0);
    chc(4, 3'h1, 7'h7, 1'b1);
    axw(12'h008, 32'h18, 2'b00);
    fst(24'h10);
    wt(3, 1'b0);
    trig <= 24'h10;
    wt(4, 1'b0);
    trig <= 24'h0;
    // Tie at level 4: channel 6 opts out of rotation and must go first
    dsc(8, 32'h48, 32'ha8, 7'h7f, 16'h3, 2'b01);
    dsc(9, 32'h4c, 32'hac, 7'h7f, 16'h3, 2'b01);
    chc(5, 3'h4, 7'h8, 1'b0);
    axw(12'h118, 32'h0001f12c, 2'b00);
    axw(12'h008, 32'h60, 2'b00);
    fst(24'h40);
    wt(5, 1'b0);
    chk(mm(42), pat(18));
    chk(mm(43), pat(19));
    test_done();
  end
endmodule
